// >>> trip_pkg.sv
// Constants for the direct local trip logic
package trip_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 4;
  // Time base of all settable times: one tick is 10 ms
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // Setting widths
  localparam int CUR_W = 12;
  localparam int SET_W = 12;
  // Trip delay range, 0.00 to 30.00 s, in 10 ms ticks
  localparam int TRIP_DELAY_MAX_S = 30;
  localparam logic [SET_W-1:0] TRIP_DELAY_MAX =
    SET_W'(TRIP_DELAY_MAX_S * (1_000_000_000 / TICK_NS));
  localparam logic [SET_W-1:0] TRIP_DELAY_RESET = 12'h000;
  // Release levels in 0.1 A: 25.0 A for 1 A inputs, 125.0 A for 5 A
  localparam logic [CUR_W-1:0] LVL_MAX_1A = 12'h0fa;
  localparam logic [CUR_W-1:0] LVL_MAX_5A = 12'h4e2;
  localparam logic [CUR_W-1:0] LVL_RESET = 12'h000;
  // Trip sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_TRIP  = 2'b10
  } trip_state_type;
endpackage

// >>> timer_if.sv
// Carrier between the trip sequencer and its tick timers
`timescale 1ns/1ns
`default_nettype none
interface timer_if #(parameter int LW = 12);
  logic          start;
  logic [LW-1:0] load;
  logic          expired;
  modport ctrl (output start, output load, input expired);
  modport tmr  (input start, input load, output expired);
endinterface
`default_nettype wire

// >>> tick_timer.sv
// Countdown timer in 10 ms ticks
`timescale 1ns/1ns
`default_nettype none
module tick_timer #(
  parameter int TICK_CYCLES = trip_pkg::TICK_CYCLES,
  parameter int LW          = trip_pkg::SET_W
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  timer_if.tmr      t
);
  import trip_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic [LW-1:0] cnt_r;
  logic [LW-1:0] cnt_nxt;
  logic          run_r;
  logic          run_nxt;

  always_comb
  begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (t.start)
    begin
      pre_nxt = '0;
      cnt_nxt = t.load;
      run_nxt = 1'b1;
    end
    else if (run_r && cnt_r != '0)
    begin
      if (pre_r == PRE_LAST)
      begin
        pre_nxt = '0;
        cnt_nxt = cnt_r - 1'b1;
      end
      else
      begin
        pre_nxt = pre_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_r <= '0;
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  // Expired once the loaded count has run down
  assign t.expired = run_r && (cnt_r == '0) && !t.start;
endmodule
`default_nettype wire

// >>> direct_local_trip_logic.sv
// Direct local trip: enable, block, current release, delay and hold
// Operation
// RULE_01 - On/off setting; when off no trip from the external input.
// RULE_02 - Asserted block input suppresses trips from the external input.
// RULE_03 - Trip released only when phase and ground currents exceed levels.
// RULE_04 - Trip delayed by settable time 0 to 30 s, default zero.
// RULE_05 - Same delay applies to the remote trip receive path.
// RULE_06 - Issued trip held at least the minimum trip hold time.
// RULE_07 - Function exists only when enabled in the functional scope.
// RULE_08 - Phase release level 0..25 A (1 A) or 0..125 A (5 A).
// RULE_09 - Ground release level has the same ranges and zero default.
// RULE_10 - Indications for function switched off and function blocked.
// RULE_11 - External device asserts one input for three-phase trip.
// RULE_12 - Trip raised as alarm and routed to output relays.
// RULE_13 - Trip ends only after input removed and hold time elapsed.
`timescale 1ns/1ns
`default_nettype none
module direct_local_trip_logic #(
  parameter int TICK_CYCLES = trip_pkg::TICK_CYCLES,
  parameter int RELAY_N     = 4
)
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         external_trip_input,
  input  wire logic                         block_input,
  input  wire logic                         remote_direct_trip,
  input  wire logic                         scope_enabled,
  input  wire logic                         function_enable_setting,
  input  wire logic                         rated_5a,
  input  wire logic [trip_pkg::SET_W-1:0]   trip_delay_setting,
  input  wire logic [trip_pkg::SET_W-1:0]   min_trip_hold_time,
  input  wire logic [trip_pkg::CUR_W-1:0]   phase_release_level,
  input  wire logic [trip_pkg::CUR_W-1:0]   ground_current_release_level,
  input  wire logic [trip_pkg::CUR_W-1:0]   phase_a_current,
  input  wire logic [trip_pkg::CUR_W-1:0]   phase_b_current,
  input  wire logic [trip_pkg::CUR_W-1:0]   phase_c_current,
  input  wire logic [trip_pkg::CUR_W-1:0]   ground_current,
  input  wire logic [RELAY_N-1:0]           relay_route,
  output logic                              trip_command_out,
  output logic                              trip_alarm,
  output logic [RELAY_N-1:0]                relay_out,
  output logic                              function_off_flag,
  output logic                              function_blocked_flag
);
  import trip_pkg::*;

  // Two-stage synchronisers for the external trip and block inputs
  logic ext_s1_r;
  logic ext_s1_nxt;
  logic ext_s2_r;
  logic ext_s2_nxt;
  logic blk_s1_r;
  logic blk_s1_nxt;
  logic blk_s2_r;
  logic blk_s2_nxt;

  always_comb
  begin
    ext_s1_nxt = external_trip_input;
    ext_s2_nxt = ext_s1_r;
    blk_s1_nxt = block_input;
    blk_s2_nxt = blk_s1_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_s1_nxt;
      ext_s2_r <= ext_s2_nxt;
      blk_s1_r <= blk_s1_nxt;
      blk_s2_r <= blk_s2_nxt;
    end
  end

  // Setting clamps
  logic [CUR_W-1:0] lvl_max;
  logic [CUR_W-1:0] ph_lvl;
  logic [CUR_W-1:0] gnd_lvl;
  logic [SET_W-1:0] delay_ticks;

  always_comb
  begin
    if (rated_5a)
    begin
      lvl_max = LVL_MAX_5A; // RULE_08
    end
    else
    begin
      lvl_max = LVL_MAX_1A; // RULE_08
    end
    if (phase_release_level > lvl_max)
    begin
      ph_lvl = lvl_max; // RULE_08
    end
    else
    begin
      ph_lvl = phase_release_level;
    end
    if (ground_current_release_level > lvl_max)
    begin
      gnd_lvl = lvl_max; // RULE_09
    end
    else
    begin
      gnd_lvl = ground_current_release_level;
    end
    if (trip_delay_setting > TRIP_DELAY_MAX)
    begin
      delay_ticks = TRIP_DELAY_MAX; // RULE_04
    end
    else
    begin
      delay_ticks = trip_delay_setting;
    end
  end

  // Phases compared for release
  localparam int PH_N = 3;

  // Per-phase release comparators
  logic [CUR_W-1:0] ph_cur [PH_N];
  logic [PH_N-1:0]  ph_over;

  assign ph_cur[0] = phase_a_current;
  assign ph_cur[1] = phase_b_current;
  assign ph_cur[2] = phase_c_current;

  for (genvar i = 0; i < PH_N; i++)
  begin : g_phase
    assign ph_over[i] = ph_cur[i] > ph_lvl; // RULE_03
  end

  // Arming, current release and requests
  logic armed;
  logic blocked;
  logic ph_rel;
  logic gnd_rel;
  logic local_req;
  logic remote_req;
  logic req;

  always_comb
  begin
    armed = scope_enabled && function_enable_setting; // RULE_01 RULE_07
    blocked = armed && blk_s2_r; // RULE_02
    ph_rel = |ph_over; // RULE_03
    gnd_rel = ground_current > gnd_lvl;
    local_req = ext_s2_r && ph_rel && gnd_rel; // RULE_03 RULE_11
    remote_req = remote_direct_trip; // RULE_05
    req = armed && !blocked && (local_req || remote_req); // RULE_01 RULE_02
  end

  // Delay and hold timers
  timer_if #(.LW(SET_W)) dly_t ();
  timer_if #(.LW(SET_W)) hld_t ();

  tick_timer #(.TICK_CYCLES(TICK_CYCLES), .LW(SET_W)) u_delay
  (
    .clk   (clk),
    .rst_n (rst_n),
    .t     (dly_t)
  );

  tick_timer #(.TICK_CYCLES(TICK_CYCLES), .LW(SET_W)) u_hold
  (
    .clk   (clk),
    .rst_n (rst_n),
    .t     (hld_t)
  );

  // Release condition for the trip
  logic hold_done;

  assign hold_done = hld_t.expired && !ext_s2_r && !remote_req; // RULE_13

  // Trip sequencer
  trip_state_type st_r;
  trip_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    dly_t.start = 1'b0;
    dly_t.load = delay_ticks;
    hld_t.start = 1'b0;
    hld_t.load = min_trip_hold_time;
    case (st_r)
      ST_IDLE:
      begin
        if (req)
        begin
          if (delay_ticks == '0)
          begin
            st_nxt = ST_TRIP;
            hld_t.start = 1'b1; // RULE_06
          end
          else
          begin
            st_nxt = ST_DELAY;
            dly_t.start = 1'b1; // RULE_04 RULE_05
          end
        end
      end
      ST_DELAY:
      begin
        if (!req)
        begin
          st_nxt = ST_IDLE;
        end
        else if (dly_t.expired)
        begin
          st_nxt = ST_TRIP; // RULE_04
          hld_t.start = 1'b1; // RULE_06
        end
      end
      ST_TRIP:
      begin
        if (hold_done)
        begin
          st_nxt = ST_IDLE; // RULE_13
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Trip outputs
  logic                trip_nxt;
  logic [RELAY_N-1:0]  relay_nxt;

  always_comb
  begin
    trip_nxt = (st_nxt == ST_TRIP); // RULE_06 RULE_13
  end

  for (genvar r = 0; r < RELAY_N; r++)
  begin : g_relay
    assign relay_nxt[r] = trip_nxt && relay_route[r]; // RULE_12
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_command_out <= 1'b0;
      trip_alarm <= 1'b0;
      relay_out <= '0;
    end
    else
    begin
      trip_command_out <= trip_nxt;
      trip_alarm <= trip_nxt; // RULE_12
      relay_out <= relay_nxt;
    end
  end

  // Status flags
  logic off_nxt;
  logic blk_nxt;

  always_comb
  begin
    off_nxt = !armed; // RULE_10
    blk_nxt = blocked; // RULE_10
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      function_off_flag <= 1'b1;
      function_blocked_flag <= 1'b0;
    end
    else
    begin
      function_off_flag <= off_nxt;
      function_blocked_flag <= blk_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> trip_properties.sv
// Port assertions for the direct local trip logic
`timescale 1ns/1ns
`default_nettype none
module trip_properties #(parameter int TICK_CYCLES = 4)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        external_trip_input,
  input wire logic        block_input,
  input wire logic        remote_direct_trip,
  input wire logic        scope_enabled,
  input wire logic        function_enable_setting,
  input wire logic [11:0] trip_delay_setting,
  input wire logic [11:0] min_trip_hold_time,
  input wire logic [11:0] phase_release_level,
  input wire logic [11:0] ground_current_release_level,
  input wire logic [11:0] phase_a_current,
  input wire logic [11:0] phase_b_current,
  input wire logic [11:0] phase_c_current,
  input wire logic [11:0] ground_current,
  input wire logic        trip_command_out,
  input wire logic        trip_alarm,
  input wire logic [3:0]  relay_out,
  input wire logic        function_off_flag,
  input wire logic        function_blocked_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Current release seen in the cycle that decides the trip
  logic rel_r;
  logic lvl_ok_r;

  always_ff @(posedge clk)
  begin
    rel_r <= (ground_current > ground_current_release_level) &&
             ((phase_a_current > phase_release_level) ||
              (phase_b_current > phase_release_level) ||
              (phase_c_current > phase_release_level));
    lvl_ok_r <= (phase_release_level <= trip_pkg::LVL_MAX_1A) &&
                (ground_current_release_level <= trip_pkg::LVL_MAX_1A);
  end

  chk_alarm_follow: assert property (
    trip_alarm == trip_command_out)
    else $error("alarm differs from trip");
  chk_relay_idle: assert property (
    !trip_command_out |-> relay_out == 4'h0)
    else $error("relay driven without trip");
  chk_off_flag: assert property (
    $past(rst_n) |-> function_off_flag ==
    !($past(scope_enabled) && $past(function_enable_setting)))
    else $error("off flag wrong");
  chk_off_gate: assert property (
    $rose(trip_command_out) |-> !function_off_flag)
    else $error("trip while off");
  chk_block_gate: assert property (
    $rose(trip_command_out) |-> !function_blocked_flag)
    else $error("trip while blocked");
  chk_block_flag: assert property (
    (block_input && !function_off_flag)[*4] |=> function_blocked_flag)
    else $error("blocked flag missing");
  chk_flag_excl: assert property (
    !(function_off_flag && function_blocked_flag))
    else $error("off and blocked together");
  chk_current_gate: assert property (
    $rose(trip_command_out) && !$past(remote_direct_trip) && lvl_ok_r |->
    rel_r)
    else $error("trip without current release");
  chk_min_hold: assert property (
    $rose(trip_command_out) && min_trip_hold_time * TICK_CYCLES >= 8 |->
    trip_command_out[*8])
    else $error("trip shorter than hold");
  chk_release_late: assert property (
    $fell(trip_command_out) |->
    !$past(external_trip_input, 3) && !$past(remote_direct_trip))
    else $error("trip ended with request present");
  chk_remote_fast: assert property (
    remote_direct_trip && !function_off_flag && !function_blocked_flag &&
    trip_delay_setting == 12'h000 && !trip_command_out |->
    ##[1:3] trip_command_out)
    else $error("remote trip late");
endmodule
bind direct_local_trip_logic trip_properties #(.TICK_CYCLES(TICK_CYCLES))
  trip_properties_inst (.clk, .rst_n, .external_trip_input, .block_input,
  .remote_direct_trip, .scope_enabled, .function_enable_setting,
  .trip_delay_setting, .min_trip_hold_time, .phase_release_level,
  .ground_current_release_level, .phase_a_current, .phase_b_current,
  .phase_c_current, .ground_current, .trip_command_out, .trip_alarm,
  .relay_out, .function_off_flag, .function_blocked_flag);
`default_nettype wire

// >>> ext_trip_device.sv
// External protection device driving the trip input
`timescale 1ns/1ns
`default_nettype none
module ext_trip_device
(
  input  wire logic clk,
  input  wire logic fire,
  output var logic  external_trip_input
);
  always @(posedge clk)
    external_trip_input <= fire;
endmodule
`default_nettype wire

// >>> direct_local_trip_logic_bench.sv
// Testbench for the direct local trip logic
`timescale 1ns/1ns
`default_nettype none
module direct_local_trip_logic_bench;
  logic clk = 1'b0, rst_n = 1'b0, fire = 1'b0, external_trip_input;
  logic block_input = 1'b0, remote_direct_trip = 1'b0, rated_5a = 1'b0;
  logic scope_enabled = 1'b1, function_enable_setting = 1'b1, prev = 1'b0;
  logic trip_command_out, trip_alarm, function_off_flag;
  logic function_blocked_flag;
  logic [11:0] trip_delay_setting = 12'h000, min_trip_hold_time = 12'h002;
  logic [11:0] phase_release_level = 12'h000, phase_a_current = 12'h000;
  logic [11:0] ground_current_release_level = 12'h000;
  logic [11:0] phase_b_current = 12'h000, phase_c_current = 12'h000;
  logic [11:0] ground_current = 12'h000;
  logic [3:0]  relay_route = 4'h5, relay_out;
  int cyc = 0, err_total = 0, samples_checked = 0, e, l;
  int exp_q[$];
  logic [1:0] fl;
  initial forever #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ext_trip_device ext_trip_device_inst (.clk, .fire, .external_trip_input);
  direct_local_trip_logic #(.TICK_CYCLES(4)) direct_local_trip_logic_inst
  (
    .clk, .rst_n, .external_trip_input, .block_input, .remote_direct_trip,
    .scope_enabled, .function_enable_setting, .rated_5a, .trip_delay_setting,
    .min_trip_hold_time, .phase_release_level, .ground_current_release_level,
    .phase_a_current, .phase_b_current, .phase_c_current, .ground_current,
    .relay_route, .trip_command_out, .trip_alarm, .relay_out,
    .function_off_flag, .function_blocked_flag
  );
  task cmp(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task close_out;
    $display("checked=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task shot(input bit r, input int d, input bit want);
    @(posedge clk);
    trip_delay_setting <= 12'(d);
    @(posedge clk);
    if (want)
      exp_q.push_back(cyc + (r ? 2 : 5) + (d > 0 ? 4 * d + 1 : 0));
    remote_direct_trip <= r;
    fire <= !r;
    repeat (4 * d + 6) @(posedge clk);
    remote_direct_trip <= 1'b0;
    fire <= 1'b0;
    repeat (4 * d + 40) @(posedge clk);
  endtask
  always @(negedge clk)
  begin
    prev <= trip_command_out;
    if (trip_command_out === 1'b1 && prev === 1'b0)
    begin
      if (exp_q.size() == 0)
        cmp(32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        cmp(32'(cyc >= e && cyc <= e + 4), 32'h1);
        cmp(32'(relay_out), 32'(relay_route));
        cmp(32'(trip_alarm), 32'h1);
      end
    end
  end
  initial
  begin
    void'($urandom(32'h9601));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int t = 0; t < 8; t++)
    begin
      @(posedge clk);
      l = $urandom_range(200);
      function_enable_setting <= (t != 0);
      scope_enabled <= (t != 1);
      block_input <= (t == 2);
      phase_release_level <= 12'(l);
      ground_current_release_level <= 12'(l);
      phase_a_current <= 12'(l + 1 + $urandom_range(40));
      phase_b_current <= 12'(l / 2);
      phase_c_current <= 12'(l / 3);
      ground_current <= 12'(t == 3 ? l : l + 5);
      rated_5a <= (t == 5);
      repeat (6) @(posedge clk);
      @(negedge clk);
      fl = {function_off_flag, function_blocked_flag};
      cmp(32'(fl), 32'({t < 2, t == 2}));
      shot(t >= 6, (t % 2) ? $urandom_range(3, 1) : 0, t >= 4);
      $display("test %0d done", t);
    end
    cmp(32'(exp_q.size()), 32'h0);
    close_out;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
